// file: hdl/sgen_fifo.sv
// Synchronous word FIFO for pattern memory loads
`timescale 1ns/100ps
`default_nettype none
module sgen_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    sgen_fifo_if.fifo ch
);
    import sgen_pkg::*;
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("sgen_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire          empty = (wr_q == rd_q);
    wire          push  = ch.in_valid & ~full;
    wire          pop   = ch.out_ready & ~empty;

    assign ch.in_ready  = ~full;
    assign ch.out_valid = ~empty;
    assign ch.out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= ch.in_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule // sgen_fifo
`default_nettype wire

// file: hdl/sgen_top.sv
// Serial test pattern generator with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
module sgen_top #(
    parameter int BIT_DIV   = sgen_pkg::BIT_DIV_DEF,
    parameter int MEM_WORDS = sgen_pkg::MEM_WORDS_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output var  logic        serial_o,
    output var  logic        serial_en_o,
    output var  logic        loading_o
);
    import sgen_pkg::*;
    localparam int MAW = $clog2(MEM_WORDS);

    generate
        if (BIT_DIV < 1 || MEM_WORDS < 2) begin : g_chk
            $error("sgen_top needs BIT_DIV >= 1 and MEM_WORDS >= 2");
        end
    endgenerate

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [4:0] stage_n(input logic [2:0] s);
        logic [4:0] n;
        n = 5'd7;
        unique case (s)
            3'd0: n = 5'd7;
            3'd1: n = 5'd9;
            3'd2: n = 5'd10;
            3'd3: n = 5'd11;
            3'd4: n = 5'd15;
            3'd5: n = 5'd20;
            3'd6: n = 5'd23;
            3'd7: n = 5'd31;
        endcase
        return n;
    endfunction

    function automatic logic [4:0] stage_tap(input logic [2:0] s);
        logic [4:0] t;
        t = 5'd6;
        unique case (s)
            3'd0: t = 5'd6;
            3'd1: t = 5'd5;
            3'd2: t = 5'd7;
            3'd3: t = 5'd9;
            3'd4: t = 5'd14;
            3'd5: t = 5'd3;
            3'd6: t = 5'd18;
            3'd7: t = 5'd28;
        endcase
        return t;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]     ctrl_q;
    logic [2:0]     stages_q;
    logic [30:0]    zcount_q;
    logic [2:0]     scram_q;
    logic [15:0]    dlen_q;
    logic [15:0]    rowlen_q;
    logic [15:0]    rows_q;
    logic [8:0]     blocks_q;
    logic [MAW-1:0] maddr_q;
    logic           loading_q;
    logic           done_req_q;
    logic           rd_ack_q;
    logic [31:0]    rdata_q;

    sgen_fifo_if #(.W(32)) fch ();

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        sel_mdata = (avs_address_i == OFS_MDATA);
    wire        wr_stall  = avs_write_i & sel_mdata & ~fch.in_ready;
    wire        rd_stall  = avs_read_i & ~rd_ack_q;
    wire        wr_go     = avs_write_i & ~wr_stall;
    wire [31:0] wmerge_ctrl = be_merge({24'h0, ctrl_q}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] wmerge_z  = be_merge({1'b0, zcount_q}, avs_writedata_i, avs_byteenable_i);
    wire [31:0] wmerge_lo = be_merge(32'h0, avs_writedata_i, avs_byteenable_i);
    wire        wr_ctrl   = wr_go & (avs_address_i == OFS_CTRL);
    wire [1:0]  new_mode  = wmerge_ctrl[CTRL_MODE_LO +: 2];
    wire        mode_load = wr_ctrl && (new_mode != ctrl_q[CTRL_MODE_LO +: 2])
                            && (new_mode == SGEN_ZSUB || new_mode == SGEN_DATA);
    wire        load_start = mode_load
                            | (wr_go & (avs_address_i == OFS_LOAD) & wmerge_lo[LOAD_START]);
    wire        load_done  = wr_go & (avs_address_i == OFS_LOAD) & wmerge_lo[LOAD_DONE];

    assign avs_waitrequest_o = rd_stall | wr_stall;

    // Memory load path through the FIFO
    assign fch.in_valid  = avs_write_i & sel_mdata;
    assign fch.in_data   = avs_writedata_i;
    assign fch.out_ready = loading_q;

    // ------------------------------------------------------------
    // Generator state
    // ------------------------------------------------------------
    logic [31:0]    mem_q [MEM_WORDS];
    logic [30:0]    prbs_q;
    logic [6:0]     scr_q;
    logic [31:0]    pos_q;
    logic [15:0]    col_q;
    logic [15:0]    row_q;
    logic [8:0]     block_q;
    logic [MAW+4:0] ptr_q;
    logic [15:0]    div_q;
    logic [1:0]     mode_q;

    wire        bit_en  = (div_q == 16'(BIT_DIV - 1));
    wire        run     = ctrl_q[CTRL_RUN] & ~loading_q;
    wire        step    = bit_en & run;
    wire        mode_chg = (mode_q != ctrl_q[CTRL_MODE_LO +: 2]);
    sgen_mode_t mode;
    assign mode = sgen_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);

    // PRBS source
    wire [2:0]  zs_sel   = (stages_q == 3'd7) ? 3'd6 : stages_q;
    wire [2:0]  psel     = (mode == SGEN_ZSUB) ? zs_sel : stages_q;
    wire [4:0]  pn       = stage_n(psel);
    wire [4:0]  pt       = stage_tap(psel);
    wire        prbs_bit = prbs_q[pn - 5'd1];
    wire        prbs_fb  = prbs_q[pn - 5'd1] ^ prbs_q[pt - 5'd1];
    wire [30:0] prbs_nxt = {prbs_q[29:0], prbs_fb} & ~(PRBS_SEED << pn);
    wire        scr_bit  = scr_q[6] ^ scr_q[5];
    wire [6:0]  scr_nxt  = {scr_q[5:0], scr_bit};

    // Zero substitution period
    wire [31:0] two_n    = 32'h1 << pn;
    wire        len2n    = ctrl_q[CTRL_LEN2N];
    wire [31:0] period   = len2n ? two_n : two_n - 32'h1;
    wire [31:0] zmax     = len2n ? two_n - 32'h1 : two_n - 32'h2;
    wire [31:0] zreq     = (zcount_q == 31'h0) ? 32'h1 : {1'b0, zcount_q};
    wire [31:0] zeff     = (zreq > zmax) ? zmax : zreq;
    wire        zs_last  = len2n & (pos_q == two_n - 32'h1);
    wire        zs_zero  = (pos_q < zeff);
    wire        zs_wrap  = (pos_q == period - 32'h1);
    wire        zs_bit   = zs_last ? ctrl_q[CTRL_LASTBIT]
                                   : (zs_zero ? 1'b0 : prbs_bit);

    // Stored pattern access
    wire [31:0] mem_word = mem_q[ptr_q[MAW+4:5]];
    wire        mem_bit  = mem_word[ptr_q[4:0]];
    wire [MAW+4:0] dlen_x = (MAW+5)'(dlen_q);
    wire        ptr_wrap = (ptr_q + (MAW+5)'(1) >= dlen_x);

    // Mixed structure
    wire        in_data  = (col_q < dlen_q);
    wire        row_end  = (col_q + 16'h1 >= rowlen_q);
    wire [15:0] rows_eff = (rows_q < ROWS_MIN) ? ROWS_MIN : rows_q;
    wire        blk_end  = row_end & (row_q + 16'h1 >= rows_eff);
    wire [8:0]  blks_eff = (blocks_q == 9'h0) ? 9'h1 : blocks_q;
    wire        pat_end  = blk_end & (block_q + 9'h1 >= blks_eff);
    wire        scr_area = in_data ? ((row_q != 16'h0) & scram_q[SCR_DATA])
                                   : scram_q[SCR_PRBS];
    wire        scr_on   = ctrl_q[CTRL_SCR_EN] & scr_area;
    wire        mix_raw  = in_data ? mem_bit : prbs_bit;
    wire        mix_bit  = mix_raw ^ (scr_on & scr_bit);

    logic       gen_bit;
    always_comb begin
        unique case (mode)
            SGEN_PRBS:  gen_bit = prbs_bit;
            SGEN_ZSUB:  gen_bit = zs_bit;
            SGEN_DATA:  gen_bit = mem_bit;
            SGEN_MIXED: gen_bit = mix_bit;
        endcase
    end

    wire prbs_adv = (mode == SGEN_PRBS) | ((mode == SGEN_ZSUB) & ~zs_last)
                    | ((mode == SGEN_MIXED) & ~in_data);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        unique case (avs_address_i)
            OFS_CTRL:   rmux = {24'h0, ctrl_q};
            OFS_STAGES: rmux = {29'h0, stages_q};
            OFS_ZCOUNT: rmux = {1'b0, zcount_q};
            OFS_SCRAM:  rmux = {29'h0, scram_q};
            OFS_DLEN:   rmux = {16'h0, dlen_q};
            OFS_ROWLEN: rmux = {16'h0, rowlen_q};
            OFS_ROWS:   rmux = {16'h0, rows_q};
            OFS_BLOCKS: rmux = {23'h0, blocks_q};
            OFS_MADDR:  rmux = 32'(maddr_q);
            OFS_STATUS: rmux = {7'h0, block_q, row_q[7:0], 4'h0, ~fch.in_ready,
                                fch.out_valid, done_req_q, loading_q};
            default:    rmux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ack_q <= 1'b0;
            rdata_q  <= 32'h0;
        end else begin
            rd_ack_q <= rd_stall;
            if (rd_stall) begin
                rdata_q <= rmux;
            end
        end
    end
    assign avs_readdata_o = rdata_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q   <= CTRL_RST;
            stages_q <= STAGES_RST;
            zcount_q <= ZCOUNT_RST;
            scram_q  <= 3'h0;
            dlen_q   <= DLEN_RST;
            rowlen_q <= ROWLEN_RST;
            rows_q   <= ROWS_RST;
            blocks_q <= BLOCKS_RST;
        end else if (wr_go) begin
            unique case (avs_address_i)
                OFS_CTRL:   ctrl_q   <= wmerge_ctrl[7:0];
                OFS_STAGES: stages_q <= wmerge_lo[2:0];
                OFS_ZCOUNT: zcount_q <= wmerge_z[30:0];
                OFS_SCRAM:  scram_q  <= wmerge_lo[2:0] & SCR_WMASK;
                OFS_DLEN:   dlen_q   <= wmerge_lo[15:0];
                OFS_ROWLEN: rowlen_q <= wmerge_lo[15:0];
                OFS_ROWS:   rows_q   <= wmerge_lo[15:0];
                OFS_BLOCKS: blocks_q <= wmerge_lo[8:0];
                default:    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Load control
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loading_q  <= 1'b0;
            done_req_q <= 1'b0;
            maddr_q    <= '0;
        end else begin
            if (load_start) begin
                loading_q  <= 1'b1;
                done_req_q <= 1'b0;
            end else if (load_done) begin
                done_req_q <= 1'b1;
            end else if (done_req_q & ~fch.out_valid) begin
                loading_q  <= 1'b0;
                done_req_q <= 1'b0;
            end
            if (wr_go && avs_address_i == OFS_MADDR) begin
                maddr_q <= wmerge_lo[MAW-1:0];
            end else if (fch.out_valid & loading_q) begin
                maddr_q <= maddr_q + MAW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (fch.out_valid & loading_q) begin
            mem_q[maddr_q] <= fch.out_data;
        end
    end

    sgen_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ch      (fch.fifo)
    );

    // ------------------------------------------------------------
    // Pattern generation
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 16'h0;
        end else begin
            div_q <= bit_en ? 16'h0 : div_q + 16'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q  <= 2'h0;
            prbs_q  <= PRBS_SEED;
            scr_q   <= SCR_SEED;
            pos_q   <= 32'h0;
            col_q   <= 16'h0;
            row_q   <= 16'h0;
            block_q <= 9'h0;
            ptr_q   <= '0;
        end else if (mode_chg | ~ctrl_q[CTRL_RUN]) begin
            mode_q  <= ctrl_q[CTRL_MODE_LO +: 2];
            prbs_q  <= PRBS_SEED;
            scr_q   <= SCR_SEED;
            pos_q   <= 32'h0;
            col_q   <= 16'h0;
            row_q   <= 16'h0;
            block_q <= 9'h0;
            ptr_q   <= '0;
        end else if (step) begin
            if (prbs_adv) begin
                prbs_q <= prbs_nxt;
            end
            unique case (mode)
                SGEN_PRBS: ;
                SGEN_ZSUB: begin
                    pos_q <= zs_wrap ? 32'h0 : pos_q + 32'h1;
                    if (zs_wrap) begin
                        prbs_q <= PRBS_SEED;
                    end
                end
                SGEN_DATA: begin
                    ptr_q <= ptr_wrap ? '0 : ptr_q + (MAW+5)'(1);
                end
                SGEN_MIXED: begin
                    scr_q <= scr_nxt;
                    if (in_data) begin
                        ptr_q <= ptr_q + (MAW+5)'(1);
                    end
                    col_q <= row_end ? 16'h0 : col_q + 16'h1;
                    if (row_end) begin
                        row_q <= blk_end ? 16'h0 : row_q + 16'h1;
                    end
                    if (blk_end) begin
                        block_q <= pat_end ? 9'h0 : block_q + 9'h1;
                        if (!ctrl_q[CTRL_CONSEC]) begin
                            prbs_q <= PRBS_SEED;
                        end // Otherwise state carries on
                    end
                    if (pat_end) begin
                        ptr_q <= '0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_o    <= 1'b0;
            serial_en_o <= 1'b0;
            loading_o   <= 1'b0;
        end else begin
            serial_en_o <= step;
            loading_o   <= loading_q;
            if (step) begin
                serial_o <= gen_bit ^ ctrl_q[CTRL_INV];
            end
        end
    end
endmodule // sgen_top
`default_nettype wire

// file: shared/sgen_fifo_if.sv
// Valid/ready word channel between generator modules
`timescale 1ns/100ps
`default_nettype none
interface sgen_fifo_if #(parameter int W = 32);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// file: shared/sgen_pkg.sv
// Constants, register map and types of the serial test pattern generator
package sgen_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAGES = 8'h04;
    localparam logic [7:0] OFS_ZCOUNT = 8'h08;
    localparam logic [7:0] OFS_SCRAM  = 8'h0C;
    localparam logic [7:0] OFS_DLEN   = 8'h10;
    localparam logic [7:0] OFS_ROWLEN = 8'h14;
    localparam logic [7:0] OFS_ROWS   = 8'h18;
    localparam logic [7:0] OFS_BLOCKS = 8'h1C;
    localparam logic [7:0] OFS_MADDR  = 8'h20;
    localparam logic [7:0] OFS_MDATA  = 8'h24;
    localparam logic [7:0] OFS_LOAD   = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_INV     = 2;
    localparam int CTRL_RUN     = 3;
    localparam int CTRL_SCR_EN  = 4;
    localparam int CTRL_CONSEC  = 5;
    localparam int CTRL_LEN2N   = 6;
    localparam int CTRL_LASTBIT = 7;
    localparam int SCR_FIRST    = 0;
    localparam int SCR_DATA     = 1;
    localparam int SCR_PRBS     = 2;
    localparam int LOAD_START   = 0;
    localparam int LOAD_DONE    = 1;
    localparam logic [2:0]  SCR_WMASK = 3'h6;
    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [2:0]  STAGES_RST   = 3'h4;
    localparam logic [30:0] ZCOUNT_RST   = 31'h0000_0001;
    localparam logic [15:0] DLEN_RST     = 16'h0800;
    localparam logic [15:0] ROWLEN_RST   = 16'h0C00;
    localparam logic [15:0] ROWS_RST     = 16'h0002;
    localparam logic [8:0]  BLOCKS_RST   = 9'h001;
    localparam logic [8:0]  BLOCKS_MAX   = 9'h1FF;
    localparam logic [15:0] ROWS_MIN     = 16'h0002;
    localparam logic [30:0] PRBS_SEED    = 31'h7FFF_FFFF;
    localparam logic [6:0]  SCR_SEED     = 7'h7F;
    localparam int          BIT_DIV_DEF  = 4;
    localparam int          MEM_WORDS_DEF = 256;
    localparam int          FIFO_DEPTH   = 8;

    typedef enum logic [1:0] {
        SGEN_PRBS  = 2'h0,
        SGEN_ZSUB  = 2'h1,
        SGEN_DATA  = 2'h2,
        SGEN_MIXED = 2'h3
    } sgen_mode_t;
endpackage

// file: testbench/sgen_props.sv
// Port checks of the pattern generator top
`timescale 1ns/100ps
`default_nettype none
module sgen_props
    import sgen_pkg::*;
#(
    parameter int BIT_DIV = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        serial_o,
    input wire logic        serial_en_o,
    input wire logic        loading_o
);
    // ----------------------------------------
    // Load tracking
    // ----------------------------------------
    logic ld_wr;
    logic rd_ok;
    logic done_q;
    assign ld_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_LOAD;
    assign rd_ok = avs_read_i && !avs_waitrequest_o;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) done_q <= 1'b0;
        else if (ld_wr && avs_writedata_i[LOAD_DONE] && !avs_writedata_i[LOAD_START])
            done_q <= 1'b1;
        else if (!loading_o) done_q <= 1'b0;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    rd_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
        else $error("Read answered without wait state");
    rd_done_a: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("Read not answered after one wait state");
    wr_fast_a: assert property (avs_write_i && avs_address_i != OFS_MDATA |-> !avs_waitrequest_o)
        else $error("Register write stalled");
    load_pause_a: assert property (loading_o |-> !serial_en_o)
        else $error("Bit sent while loading");
    load_start_a: assert property (ld_wr && avs_writedata_i[LOAD_START] |-> ##[1:3] loading_o)
        else $error("Load start did not raise loading");
    load_hold_a: assert property ($fell(loading_o) |-> done_q)
        else $error("Loading dropped before done");
    bit_hold_a: assert property (!serial_en_o |-> $stable(serial_o))
        else $error("Serial bit changed without strobe");
    en_pulse_a: assert property (serial_en_o |=> BIT_DIV == 1 || !serial_en_o)
        else $error("Bit strobe longer than one cycle");
    unmapped_a: assert property (rd_ok && avs_address_i > OFS_STATUS |-> avs_readdata_o == 32'h0)
        else $error("Unmapped read not zero");
    first_row_a: assert property (rd_ok && avs_address_i == OFS_SCRAM |-> !avs_readdata_o[0])
        else $error("First row scramble select stored");
    blk_max_a: assert property (rd_ok && avs_address_i == OFS_BLOCKS |-> avs_readdata_o[31:9] == 0)
        else $error("Block count wider than nine bits");
    cover property (ld_wr ##[1:3] loading_o);
    cover property ($fell(loading_o));
    cover property (serial_en_o && serial_o);
endmodule // sgen_props
`default_nettype wire

// file: testbench/sgen_rx_model.sv
// Receiver model that collects every generated bit
`timescale 1ns/100ps
`default_nettype none
module sgen_rx_model (
    input wire logic clk_i,
    input wire logic serial_i,
    input wire logic serial_en_i
);
    // ----------------------------------------
    // Bit capture
    // ----------------------------------------
    logic bits[$];
    always @(posedge clk_i) begin
        if (serial_en_i) bits.push_back(serial_i);
    end
endmodule // sgen_rx_model
`default_nettype wire

// file: testbench/test_serial_test_pattern_generator.sv
// Self-checking bench of the serial test pattern generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_serial_test_pattern_generator;
    import sgen_pkg::*;
    logic        clk_i;
    logic        rst_n_i;
    logic [7:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        serial_o;
    logic        serial_en_o;
    logic        loading_o;
    logic [31:0] exq[$];
    logic        bq[$];
    logic        p[$];
    logic [31:0] w;
    logic [31:0] rx;
    logic [7:0]  cw;
    int          n_errors;
    int          checks_done;
    int          ones;
    int          pl;
    sgen_top #(.BIT_DIV(2)) i_sgen_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .serial_o(serial_o), .serial_en_o(serial_en_o), .loading_o(loading_o));
    sgen_rx_model i_sgen_rx_model (.clk_i(clk_i), .serial_i(serial_o), .serial_en_i(serial_en_o));
    // ----------------------------------------
    // Tasks and read monitor
    // ----------------------------------------
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (!wr) exq.push_back(d);
        @(posedge clk_i);
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task get(input int n);
        while (i_sgen_rx_model.bits.size() < n) @(posedge clk_i);
        bq = i_sgen_rx_model.bits;
    endtask
    task clr;
        repeat (4) @(posedge clk_i);
        i_sgen_rx_model.bits.delete();
    endtask
    task wait_load(input logic v);
        for (int k = 0; k < 20 && loading_o !== v; k++) @(posedge clk_i);
    endtask
    task print_verdict;
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            rx = exq.pop_front();
            `CHK(avs_readdata_o, rx)
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        print_verdict;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst_n_i = 1'b0;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        void'($urandom(50543));
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(0, OFS_CTRL, 32'h0);
        bus(0, OFS_STAGES, 32'h4);
        bus(0, OFS_ZCOUNT, 32'h1);
        bus(0, OFS_ROWS, 32'h2);
        bus(0, 8'h30, 32'h0);
        bus(1, OFS_SCRAM, 32'h7);
        bus(0, OFS_SCRAM, 32'h6);
        bus(1, OFS_BLOCKS, 32'h1FF);
        bus(0, OFS_BLOCKS, 32'h1FF);
        w = {16'h0, 16'($urandom)};
        bus(1, OFS_DLEN, w);
        bus(0, OFS_DLEN, w);
        $display("Register test done");
        bus(1, OFS_STAGES, 32'h0);
        bus(1, OFS_CTRL, 32'h8);
        get(254);
        ones = 0;
        for (int i = 0; i < 127; i++) begin
            ones += int'(bq[i]);
            `CHK(bq[i], bq[i + 127])
        end
        `CHK(ones, 64)
        p = bq;
        bus(1, OFS_CTRL, 32'h0);
        clr;
        bus(1, OFS_CTRL, 32'hC);
        get(127);
        for (int i = 0; i < 127; i++) `CHK(bq[i], ~p[i])
        $display("Pseudo-random test done");
        bus(1, OFS_ZCOUNT, 32'h5);
        bus(1, OFS_CTRL, 32'h1);
        wait_load(1);
        `CHK(loading_o, 1'b1)
        bus(1, OFS_LOAD, 32'h2);
        wait_load(0);
        `CHK(loading_o, 1'b0)
        for (int c = 0; c < 3; c++) begin
            cw = (c == 0) ? 8'hC1 : (c == 1) ? 8'h41 : 8'h81;
            pl = (c == 2) ? 127 : 128;
            clr;
            bus(1, OFS_CTRL, {24'h0, cw | 8'h08});
            get(2 * pl);
            for (int j = 0; j < 5; j++) `CHK(bq[j] | bq[pl + j], 1'b0)
            if (pl == 128) `CHK(bq[127], cw[7])
            bus(1, OFS_CTRL, {24'h0, cw});
        end
        $display("Zero substitution test done");
        bus(1, OFS_CTRL, 32'h0);
        bus(1, OFS_MADDR, 32'h0);
        w = $urandom;
        for (int k = 0; k < 8; k++) bus(1, OFS_MDATA, (k == 0) ? w : $urandom);
        bus(0, OFS_STATUS, 32'hC);
        bus(1, OFS_DLEN, 32'h20);
        bus(1, OFS_CTRL, 32'h2);
        wait_load(1);
        `CHK(loading_o, 1'b1)
        bus(1, OFS_LOAD, 32'h3);
        bus(1, OFS_LOAD, 32'h2);
        wait_load(0);
        bus(0, OFS_STATUS, 32'h0);
        clr;
        bus(1, OFS_CTRL, 32'hA);
        get(64);
        for (int i = 0; i < 64; i++) `CHK(bq[i], w[i % 32])
        $display("Data memory test done");
        bus(1, OFS_ROWLEN, 32'h28);
        for (int c = 0; c < 2; c++) begin
            bus(1, OFS_CTRL, 32'h3);
            clr;
            bus(1, OFS_CTRL, c ? 32'h2B : 32'hB);
            get(120);
            for (int i = 0; i < 8; i++) begin
                `CHK(bq[i], w[i])
                `CHK(bq[112 + i], p[c * 16 + i])
            end
        end
        $display("Mixed test done");
        print_verdict;
    end
endmodule // test_serial_test_pattern_generator
bind sgen_top sgen_props #(.BIT_DIV(BIT_DIV)) i_sgen_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .serial_o(serial_o), .serial_en_o(serial_en_o), .loading_o(loading_o));
`default_nettype wire
